// ===== rtl/ite_encoder.sv
`timescale 1ns/1ps
// How it works
// - jal: own pc, then target
// - jalr otherwise: destination pc if storedata
// - branch: taken or not-taken header
// - taken branch: own pc then target
// - load: address and data sequences if enabled
// - store: address and data sequences if enabled
// - traps: like jal plus privilege
// - interrupt: old pc, privilege, new pc
// - csr read loaddata, write storedata
// - after drops emit trace-disabled header
// - bit 24 wrapped flag, read only
// - bits 23:16 emit enables, reset zero
// - bits 9:8 buffer-full policy
// - destination field, reset system ram
// - stall bit resets one, stalls hart
// - discard resets pointer, clears wrapped
// - 0x729 holds region start
// - 0x72a exclusive end, never written
// - 0x72b next write address
// - nibbles packed from low bits up
// - value: size nibble then low nibbles
// - eight sync points padded with nops
// - header nibble encodings
module ite_encoder
  import ite_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // register port
  input wire logic [11:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // retirement stream
  input wire ite_retire_s ret_info,
  input wire logic ret_valid,
  output logic ret_ready,
  output logic hart_stall,
  output logic trace_full_exc,
  // system bus write port
  output ite_mem_s mem_out,
  input wire logic mem_ack
);
  // ****************************************************************
  // registers
  // ****************************************************************
  logic [7:0] en;
  logic [1:0] full_act;
  logic [1:0] dest;
  logic stall_en;
  logic wrapped;
  logic stopped;
  logic [31:0] buf_start;
  logic [31:0] buf_end;
  logic [31:0] wptr;
  logic [31:0] timestamp;

  wire wr_ctrl = reg_wr && (reg_addr == ITE_ADDR_CTRL);
  wire wr_start = reg_wr && (reg_addr == ITE_ADDR_START);
  wire wr_end = reg_wr && (reg_addr == ITE_ADDR_END);
  wire discard = wr_ctrl && reg_wdata[ITE_BIT_DISCARD] && (dest == ITE_DEST_SYSRAM);

  wire [31:0] ctrl_word = {7'h00, wrapped, en, 6'h00, full_act, 2'h0, dest, 1'b0, stall_en,
                           1'b0, 1'b1};
  wire [31:0] rd_mux = (reg_addr == ITE_ADDR_CTRL) ? ctrl_word :
                       (reg_addr == ITE_ADDR_START) ? buf_start :
                       (reg_addr == ITE_ADDR_END) ? buf_end :
                       (reg_addr == ITE_ADDR_WPTR) ? wptr : 32'h0000_0000;

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
      reg_rdata <= 32'h0000_0000;
    else
      reg_rdata <= reg_rd ? rd_mux : 32'h0000_0000;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      en <= ITE_RST_EN;
      full_act <= ITE_RST_FULL;
      dest <= ITE_RST_DEST;
      stall_en <= ITE_RST_STALL;
      buf_start <= ITE_RST_ADDR;
      buf_end <= ITE_RST_ADDR;
      timestamp <= 32'h0000_0000;
    end
    else
    begin
      timestamp <= timestamp + 32'h0000_0001;
      if (wr_ctrl)
      begin
        en <= reg_wdata[ITE_BIT_EN_HI:ITE_BIT_EN_LO];
        full_act <= reg_wdata[ITE_BIT_FULL_HI:ITE_BIT_FULL_LO];
        dest <= reg_wdata[ITE_BIT_DEST_HI:ITE_BIT_DEST_LO];
        stall_en <= reg_wdata[ITE_BIT_STALL];
      end
      if (wr_start)
        buf_start <= reg_wdata;
      if (wr_end)
        buf_end <= reg_wdata;
    end
  end

  // ****************************************************************
  // event to sequence list
  // ****************************************************************
  // six slots, up to four sequences per event; value=0 means header only, except priv which adds one data nibble
  logic [5:0] q_on;
  logic [5:0][3:0] q_hdr;
  logic [5:0] q_val;
  logic [5:0][31:0] q_data;

  wire two_pc = !en[ITE_EN_BRANCH] && en[ITE_EN_PC];
  wire ret_t = (ret_info.kind == ITE_K_BRANCH) && ret_info.taken;

  always_comb
  begin
    q_on = 6'h00;
    q_hdr = '0;
    q_val = 6'h00;
    q_data = '0;
    q_hdr[5] = ITE_H_TIME;
    q_val[5] = 1'b1;
    q_data[5] = timestamp;
    q_on[5] = en[ITE_EN_TIME] && (ret_info.kind != ITE_K_NONE);
    case (ret_info.kind)
      ITE_K_JAL, ITE_K_TRAP:
      begin
        q_on[0] = two_pc;
        q_hdr[0] = ITE_H_PC;
        q_val[0] = 1'b1;
        q_data[0] = ret_info.pc;
        q_on[1] = two_pc;
        q_hdr[1] = ITE_H_PC;
        q_val[1] = 1'b1;
        q_data[1] = ret_info.target;
        q_on[2] = (ret_info.kind == ITE_K_TRAP) && en[ITE_EN_PRIV];
        q_hdr[2] = ITE_H_PRIV;
        q_data[2] = {28'h0000000, ret_info.priv};
      end
      ITE_K_JALR:
      begin
        q_on[0] = two_pc;
        q_hdr[0] = ITE_H_PC;
        q_val[0] = 1'b1;
        q_data[0] = ret_info.pc;
        q_on[1] = two_pc || en[ITE_EN_STDATA];
        q_hdr[1] = ITE_H_PC;
        q_val[1] = 1'b1;
        q_data[1] = ret_info.target;
      end
      ITE_K_BRANCH:
      begin
        q_on[0] = en[ITE_EN_BRANCH];
        q_hdr[0] = ret_info.taken ? ITE_H_BTAKEN : ITE_H_BNOT;
        q_on[1] = two_pc && ret_t;
        q_hdr[1] = ITE_H_PC;
        q_val[1] = 1'b1;
        q_data[1] = ret_info.pc;
        q_on[2] = two_pc && ret_t;
        q_hdr[2] = ITE_H_PC;
        q_val[2] = 1'b1;
        q_data[2] = ret_info.target;
      end
      ITE_K_LOAD, ITE_K_STORE:
      begin
        q_on[0] = (ret_info.kind == ITE_K_LOAD) ? en[ITE_EN_LDADDR] : en[ITE_EN_STADDR];
        q_hdr[0] = (ret_info.kind == ITE_K_LOAD) ? ITE_H_LDADDR : ITE_H_STADDR;
        q_val[0] = 1'b1;
        q_data[0] = ret_info.addr;
        q_on[1] = (ret_info.kind == ITE_K_LOAD) ? en[ITE_EN_LDDATA] : en[ITE_EN_STDATA];
        q_hdr[1] = (ret_info.kind == ITE_K_LOAD) ? ITE_H_LDDATA : ITE_H_STDATA;
        q_val[1] = 1'b1;
        q_data[1] = ret_info.data;
      end
      ITE_K_IRQ:
      begin
        q_on[0] = en[ITE_EN_PC];
        q_hdr[0] = ITE_H_PC;
        q_val[0] = 1'b1;
        q_data[0] = ret_info.pc;
        q_on[1] = en[ITE_EN_PRIV];
        q_hdr[1] = ITE_H_PRIV;
        q_data[1] = {28'h0000000, ret_info.priv};
        q_on[2] = en[ITE_EN_PC];
        q_hdr[2] = ITE_H_PC;
        q_val[2] = 1'b1;
        q_data[2] = ret_info.target;
      end
      ITE_K_CSR:
      begin
        q_on[0] = ret_info.csr_rd && en[ITE_EN_LDDATA];
        q_hdr[0] = ITE_H_LDDATA;
        q_val[0] = 1'b1;
        q_data[0] = ret_info.data;
        q_on[1] = ret_info.csr_wr && en[ITE_EN_STDATA];
        q_hdr[1] = ITE_H_STDATA;
        q_val[1] = 1'b1;
        q_data[1] = ret_info.addr;
      end
      default:
      begin
        q_on[5] = 1'b0;
      end
    endcase
  end

  // ****************************************************************
  // sequence emitter
  // ****************************************************************
  ite_state_e state;
  logic [5:0] p_on;
  logic [5:0][3:0] p_hdr;
  logic [5:0] p_val;
  logic [5:0][31:0] p_data;
  logic [2:0] idx;
  logic [3:0] vcnt;
  logic dropped;
  logic [31:0] word;
  logic [2:0] nib;

  function automatic logic [2:0] ite_first(input logic [5:0] m);
    ite_first = 3'h0;
    for (int i = 5; i >= 0; i--)
      if (m[i])
        ite_first = 3'(i);
  endfunction

  wire busy = (state != ITE_S_IDLE);
  wire tracing = (dest == ITE_DEST_SYSRAM) && !stopped;
  wire has_work = |q_on;
  // hart held whenever the emitter is busy and stall is set, even if the event has nothing to emit
  assign ret_ready = !(busy && stall_en);
  assign hart_stall = ret_valid && !ret_ready;
  wire take = ret_valid && ret_ready && !busy && has_work && tracing;
  wire drop = ret_valid && busy && !stall_en && has_work && tracing;

  // sync point spacing: region split in eight word-aligned parts
  wire [31:0] span = buf_end - buf_start;
  wire [31:0] seg = {span[31:5], 5'h00} >> 3;
  wire [31:0] rel = wptr - buf_start;
  // a sequence may cross neither a sync point nor the region end
  wire [31:0] to_seg = seg - (rel % seg);
  wire [31:0] to_end = buf_end - wptr;
  wire [31:0] room = (to_seg < to_end) ? to_seg : to_end;
  wire [31:0] left = {room[30:0], 1'b0} - {29'h0, nib};
  wire [31:0] need = (dropped || !(p_val[idx] || p_hdr[idx] == ITE_H_PRIV)) ? 32'h1 :
                     (p_val[idx] ? 32'ha : 32'h2);
  // segments under 16 nibbles would pad for ever, so sync is given up there
  wire near_sync = (seg >= 32'h8) && !stopped && (need > left);

  wire mem_stall = mem_out.req && !mem_ack;
  logic emit;
  logic [3:0] emit_nib;
  always_comb
  begin
    emit = 1'b0;
    emit_nib = ITE_H_NOP;
    case (state)
      ITE_S_HDR:
      begin
        emit = 1'b1;
        emit_nib = near_sync ? ITE_H_NOP :
                   (dropped ? ITE_H_TROFF : p_hdr[idx]);
      end
      ITE_S_SIZE:
      begin
        emit = 1'b1;
        emit_nib = p_val[idx] ? ITE_VAL_SIZE : p_data[idx][3:0];
      end
      ITE_S_VAL:
      begin
        emit = 1'b1;
        emit_nib = p_data[idx][{vcnt[2:0], 2'b00} +: 4];
      end
      default:
      begin
        emit = 1'b0;
      end
    endcase
  end
  wire step = emit && !mem_stall;
  wire hdr_pad = (state == ITE_S_HDR) && near_sync;
  wire [5:0] rest = p_on & ~(6'h01 << idx);

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      state <= ITE_S_IDLE;
      p_on <= 6'h00;
      p_hdr <= '0;
      p_val <= 6'h00;
      p_data <= '0;
      idx <= 3'h0;
      vcnt <= 4'h0;
      dropped <= 1'b0;
    end
    else
    begin
      if (drop)
        dropped <= 1'b1;
      case (state)
        ITE_S_IDLE:
          if (take)
          begin
            p_on <= q_on;
            p_hdr <= q_hdr;
            p_val <= q_val;
            p_data <= q_data;
            idx <= ite_first(q_on);
            state <= ITE_S_HDR;
          end
        ITE_S_HDR:
          if (step && !hdr_pad)
          begin
            if (dropped)
              dropped <= drop;
            else if (p_hdr[idx] == ITE_H_PRIV || p_val[idx])
              state <= ITE_S_SIZE;
            else if (rest == 6'h00)
              state <= ITE_S_IDLE;
            else
            begin
              p_on <= rest;
              idx <= ite_first(rest);
            end
          end
        ITE_S_SIZE:
          if (step)
          begin
            vcnt <= 4'h0;
            if (p_val[idx])
              state <= ITE_S_VAL;
            else if (rest == 6'h00)
              state <= ITE_S_IDLE;
            else
            begin
              p_on <= rest;
              idx <= ite_first(rest);
              state <= ITE_S_HDR;
            end
          end
        ITE_S_VAL:
          if (step)
          begin
            vcnt <= vcnt + 4'h1;
            if (vcnt == ITE_VAL_SIZE)
            begin
              p_on <= rest;
              idx <= ite_first(rest);
              state <= (rest == 6'h00) ? ITE_S_IDLE : ITE_S_HDR;
            end
          end
        default:
          state <= ITE_S_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // word packing and buffer pointer
  // ****************************************************************
  wire word_done = step && (nib == 3'h7);
  wire [31:0] wptr_inc = wptr + 32'h4;
  wire at_end = (wptr_inc >= buf_end);

  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      word <= 32'h0000_0000;
      nib <= 3'h0;
      wptr <= ITE_RST_ADDR;
      wrapped <= 1'b0;
      stopped <= 1'b0;
      trace_full_exc <= 1'b0;
      mem_out <= '0;
    end
    else
    begin
      trace_full_exc <= 1'b0;
      if (mem_out.req && mem_ack)
        mem_out.req <= 1'b0;
      if (step)
      begin
        word[{nib, 2'b00} +: 4] <= emit_nib;
        nib <= nib + 3'h1;
      end
      // once stopped the rest of an event is dropped, not written
      if (word_done && !stopped)
      begin
        mem_out.req <= 1'b1;
        mem_out.addr <= wptr;
        mem_out.data <= {emit_nib, word[27:0]};
      end
      if (discard)
      begin
        wptr <= buf_start;
        wrapped <= 1'b0;
        stopped <= 1'b0;
        nib <= 3'h0;
      end
      else if (word_done && !stopped)
      begin
        if (!at_end)
          wptr <= wptr_inc;
        else if (full_act == ITE_FULL_WRAP)
        begin
          wptr <= buf_start;
          wrapped <= 1'b1;
        end
        else if (full_act == ITE_FULL_STOP)
          stopped <= 1'b1;
        else if (full_act == ITE_FULL_EXC)
        begin
          stopped <= 1'b1;
          trace_full_exc <= 1'b1;
        end
      end
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  a_discard_ptr: assert property (@(posedge clk_sys) disable iff (!rstn)
    discard |=> (wptr == $past(buf_start)) && !wrapped)
    else $error("discard did not reset pointer");
  a_wrap_flag: assert property (@(posedge clk_sys) disable iff (!rstn)
    (word_done && at_end && !discard && !stopped && full_act == ITE_FULL_WRAP) |=> wrapped)
    else $error("wrap did not set flag");
  a_stall_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
    (busy && stall_en) |-> !ret_ready)
    else $error("hart not held while busy");
  a_size_nibble: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state == ITE_S_SIZE && p_val[idx] && step) |=> state == ITE_S_VAL)
    else $error("value did not follow size");
  a_drop_mark: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state == ITE_S_HDR && dropped && !hdr_pad) |-> emit_nib == ITE_H_TROFF)
    else $error("drop not reported");
  a_end_bound: assert property (@(posedge clk_sys) disable iff (!rstn)
    (mem_out.req && buf_end > buf_start && $rose(mem_out.req)) |-> mem_out.addr < buf_end)
    else $error("write beyond region end");
  a_ctrl_reset: assert property (@(posedge clk_sys)
    $rose(rstn) |-> (en == ITE_RST_EN) && stall_en)
    else $error("control reset values wrong");
  a_read_ptr: assert property (@(posedge clk_sys) disable iff (!rstn)
    (reg_rd && reg_addr == ITE_ADDR_WPTR && !discard && !word_done) |=> reg_rdata == wptr)
    else $error("pointer read wrong");
endmodule // ite_encoder

// ===== rtl/ite_pkg.sv
package ite_pkg;
  // ****************************************************************
  // register map
  // ****************************************************************
  localparam logic [11:0] ITE_ADDR_CTRL = 12'h728;
  localparam logic [11:0] ITE_ADDR_START = 12'h729;
  localparam logic [11:0] ITE_ADDR_END = 12'h72a;
  localparam logic [11:0] ITE_ADDR_WPTR = 12'h72b;
  // ****************************************************************
  // control fields
  // ****************************************************************
  localparam int ITE_BIT_WRAPPED = 24;
  localparam int ITE_BIT_EN_HI = 23;
  localparam int ITE_BIT_EN_LO = 16;
  localparam int ITE_BIT_FULL_HI = 9;
  localparam int ITE_BIT_FULL_LO = 8;
  localparam int ITE_BIT_DEST_HI = 5;
  localparam int ITE_BIT_DEST_LO = 4;
  localparam int ITE_BIT_STALL = 2;
  localparam int ITE_BIT_DISCARD = 1;
  localparam int ITE_BIT_SUPPORTED = 0;
  // enable index within the 8-bit group
  localparam int ITE_EN_PC = 0;
  localparam int ITE_EN_BRANCH = 1;
  localparam int ITE_EN_PRIV = 2;
  localparam int ITE_EN_LDADDR = 3;
  localparam int ITE_EN_STADDR = 4;
  localparam int ITE_EN_LDDATA = 5;
  localparam int ITE_EN_STDATA = 6;
  localparam int ITE_EN_TIME = 7;
  localparam logic [7:0] ITE_RST_EN = 8'h00;
  localparam logic [1:0] ITE_RST_FULL = 2'h0;
  localparam logic [1:0] ITE_RST_DEST = 2'h1;
  localparam logic ITE_RST_STALL = 1'b1;
  localparam logic [31:0] ITE_RST_ADDR = 32'h0000_0000;
  localparam logic [1:0] ITE_FULL_WRAP = 2'h0;
  localparam logic [1:0] ITE_FULL_STOP = 2'h1;
  localparam logic [1:0] ITE_FULL_EXC = 2'h2;
  localparam logic [1:0] ITE_DEST_SYSRAM = 2'h1;
  localparam int ITE_SYNC_POINTS = 8;
  // ****************************************************************
  // header nibbles
  // ****************************************************************
  localparam logic [3:0] ITE_H_NOP = 4'h0;
  localparam logic [3:0] ITE_H_PC = 4'h1;
  localparam logic [3:0] ITE_H_BTAKEN = 4'h2;
  localparam logic [3:0] ITE_H_BNOT = 4'h3;
  localparam logic [3:0] ITE_H_TRON = 4'h4;
  localparam logic [3:0] ITE_H_TROFF = 4'h5;
  localparam logic [3:0] ITE_H_PRIV = 4'h6;
  localparam logic [3:0] ITE_H_HART = 4'h7;
  localparam logic [3:0] ITE_H_LDADDR = 4'h8;
  localparam logic [3:0] ITE_H_STADDR = 4'h9;
  localparam logic [3:0] ITE_H_LDDATA = 4'ha;
  localparam logic [3:0] ITE_H_STDATA = 4'hb;
  localparam logic [3:0] ITE_H_TIME = 4'hc;
  // value sequences always carry 32 bits: size nibble 7, then 8 nibbles
  localparam logic [3:0] ITE_VAL_SIZE = 4'h7;

  typedef enum logic [3:0] {
    ITE_K_NONE = 4'h0,
    ITE_K_JAL = 4'h1,
    ITE_K_JALR = 4'h2,
    ITE_K_BRANCH = 4'h3,
    ITE_K_LOAD = 4'h4,
    ITE_K_STORE = 4'h5,
    ITE_K_TRAP = 4'h6,
    ITE_K_IRQ = 4'h7,
    ITE_K_CSR = 4'h8
  } ite_kind_e;

  typedef struct packed {
    ite_kind_e kind;
    logic [31:0] pc;
    logic [31:0] target;
    logic taken;
    logic [31:0] addr;
    logic [31:0] data;
    logic csr_rd;
    logic csr_wr;
    logic [3:0] priv;
  } ite_retire_s;

  typedef struct packed {
    logic req;
    logic [31:0] addr;
    logic [31:0] data;
  } ite_mem_s;

  typedef enum logic [1:0] {
    ITE_S_IDLE = 2'b00,
    ITE_S_HDR = 2'b01,
    ITE_S_SIZE = 2'b10,
    ITE_S_VAL = 2'b11
  } ite_state_e;
endpackage

// ===== test/ite_ram_model.sv
`timescale 1ns/1ps
// ****************************************************************
// system bus ram: acks after 0, 1 or 2 wait cycles in turn
// ****************************************************************
module ite_ram_model
  import ite_pkg::*;
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // bus write port
  input wire ite_mem_s mem_in,
  output logic mem_ack
);
  logic [31:0] mem [logic [31:0]];
  int nwr = 0;
  logic [1:0] delay;
  logic [1:0] wait_cnt;
  // varying latency so the encoder must hold its word while waiting
  assign mem_ack = mem_in.req && (wait_cnt == delay);
  always @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      wait_cnt <= 2'h0;
      delay <= 2'h0;
    end
    else if (mem_ack)
    begin
      wait_cnt <= 2'h0;
      delay <= (delay == 2'h2) ? 2'h0 : delay + 2'h1;
      mem[mem_in.addr] = mem_in.data;
      nwr = nwr + 1;
    end
    else if (mem_in.req)
      wait_cnt <= wait_cnt + 2'h1;
  end
endmodule // ite_ram_model

// ===== test/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import ite_pkg::*;
;
  logic clk_sys;
  logic rstn;
  logic [11:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  ite_retire_s ret_info;
  logic ret_valid;
  logic ret_ready;
  logic hart_stall;
  logic trace_full_exc;
  ite_mem_s mem_out;
  logic mem_ack;
  int num_errors = 0;
  int comparisons = 0;
  int n_exc = 0;
  logic [3:0] exp_q[$];
  logic [31:0] pa = 32'h1234_5678;
  logic [31:0] pb = 32'h9abc_def0;
  logic [31:0] ad = 32'h0f1e_2d3c;
  logic [31:0] da = 32'h8070_6050;

  ite_encoder ite_encoder_i (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ret_info(ret_info), .ret_valid(ret_valid), .ret_ready(ret_ready),
    .hart_stall(hart_stall), .trace_full_exc(trace_full_exc), .mem_out(mem_out),
    .mem_ack(mem_ack));
  ite_ram_model ite_ram_model_i (.clk_sys(clk_sys), .rstn(rstn), .mem_in(mem_out),
    .mem_ack(mem_ack));

  initial
  begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  always @(posedge clk_sys)
    if (trace_full_exc === 1'b1)
      n_exc++;

  // ****************************************************************
  // helpers
  // ****************************************************************
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_write(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp, input string what);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    check(what, exp, reg_rdata);
  endtask

  function automatic logic [31:0] ctrl(input logic [7:0] en, input logic [1:0] full,
      input logic stall, input logic disc);
    return {8'h00, en, 6'h00, full, 2'h0, ITE_DEST_SYSRAM, 1'b0, stall, disc, 1'b0};
  endfunction

  function automatic void seq(input logic [3:0] h, input logic [31:0] v);
    exp_q.push_back(h);
    exp_q.push_back(ITE_VAL_SIZE);
    for (int i = 0; i < 8; i++)
      exp_q.push_back(v[4*i +: 4]);
  endfunction

  // ready is combinational, so it is judged 1 ns after the edge
  task automatic wait_idle();
    int n = 0;
    @(posedge clk_sys);
    #1;
    while (ret_ready !== 1'b1 && n < 2000)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    check("emitter idle", 32'h1, 32'(ret_ready));
  endtask

  task automatic go(input ite_kind_e k, input logic tk, input logic rd, input logic wr,
      input logic must);
    int n = 0;
    logic rdy;
    @(posedge clk_sys);
    ret_info <= '{k, pa, pb, tk, ad, da, rd, wr, 4'h9};
    ret_valid <= 1'b1;
    #1;
    while (ret_ready !== 1'b1 && n < (must ? 2000 : 200))
    begin
      check("hart stall", 32'h1, 32'(hart_stall));
      @(posedge clk_sys);
      #1;
      n++;
    end
    rdy = ret_ready;
    @(posedge clk_sys);
    ret_valid <= 1'b0;
    if (must)
    begin
      check("event taken", 32'h1, 32'(rdy));
      wait_idle();
    end
  endtask

  task automatic final_report();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (50000) @(posedge clk_sys);
    num_errors++;
    $display("[FAIL] watchdog expected done seen hang");
    final_report();
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial
  begin
    int nw;
    logic [31:0] w;
    rstn = 1'b0;
    reg_addr = 12'h000;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ret_info = '0;
    ret_valid = 1'b0;
    repeat (12) @(posedge clk_sys);
    rstn <= 1'b1;
    rd_chk(ITE_ADDR_CTRL, 32'h0000_0015, "ctrl reset");
    rd_chk(ITE_ADDR_WPTR, 32'h0, "wptr reset");
    rd_chk(12'h72c, 32'h0, "unmapped");
    reg_write(ITE_ADDR_START, 32'h1000);
    reg_write(ITE_ADDR_END, 32'h2000);
    reg_write(ITE_ADDR_WPTR, 32'h5555_5554);
    rd_chk(ITE_ADDR_START, 32'h1000, "start");
    rd_chk(ITE_ADDR_END, 32'h2000, "end");
    rd_chk(ITE_ADDR_WPTR, 32'h0, "wptr ro");
    reg_write(ITE_ADDR_CTRL, ctrl(8'h01, ITE_FULL_WRAP, 1'b1, 1'b1));
    rd_chk(ITE_ADDR_WPTR, 32'h1000, "wptr discard");
    rd_chk(ITE_ADDR_CTRL, ctrl(8'h01, 2'h0, 1'b1, 1'b0) | 32'h1, "ctrl rw");
    go(ITE_K_JAL, 1'b0, 1'b0, 1'b0, 1'b1);
    seq(ITE_H_PC, pa);
    seq(ITE_H_PC, pb);
    go(ITE_K_JALR, 1'b0, 1'b0, 1'b0, 1'b1);
    seq(ITE_H_PC, pa);
    seq(ITE_H_PC, pb);
    go(ITE_K_BRANCH, 1'b1, 1'b0, 1'b0, 1'b1);
    seq(ITE_H_PC, pa);
    seq(ITE_H_PC, pb);
    go(ITE_K_BRANCH, 1'b0, 1'b0, 1'b0, 1'b1);
    reg_write(ITE_ADDR_CTRL, ctrl(8'h42, ITE_FULL_WRAP, 1'b1, 1'b0));
    go(ITE_K_BRANCH, 1'b1, 1'b0, 1'b0, 1'b1);
    exp_q.push_back(ITE_H_BTAKEN);
    go(ITE_K_BRANCH, 1'b0, 1'b0, 1'b0, 1'b1);
    exp_q.push_back(ITE_H_BNOT);
    go(ITE_K_JALR, 1'b0, 1'b0, 1'b0, 1'b1);
    seq(ITE_H_PC, pb);
    reg_write(ITE_ADDR_CTRL, ctrl(8'h78, ITE_FULL_WRAP, 1'b1, 1'b0));
    go(ITE_K_LOAD, 1'b0, 1'b0, 1'b0, 1'b1);
    seq(ITE_H_LDADDR, ad);
    seq(ITE_H_LDDATA, da);
    go(ITE_K_STORE, 1'b0, 1'b0, 1'b0, 1'b1);
    seq(ITE_H_STADDR, ad);
    seq(ITE_H_STDATA, da);
    go(ITE_K_CSR, 1'b0, 1'b1, 1'b0, 1'b1);
    seq(ITE_H_LDDATA, da);
    go(ITE_K_CSR, 1'b0, 1'b0, 1'b1, 1'b1);
    seq(ITE_H_STDATA, ad);
    reg_write(ITE_ADDR_CTRL, ctrl(8'h05, ITE_FULL_WRAP, 1'b1, 1'b0));
    go(ITE_K_TRAP, 1'b0, 1'b0, 1'b0, 1'b1);
    seq(ITE_H_PC, pa);
    seq(ITE_H_PC, pb);
    exp_q.push_back(ITE_H_PRIV);
    exp_q.push_back(4'h9);
    go(ITE_K_IRQ, 1'b0, 1'b0, 1'b0, 1'b1);
    seq(ITE_H_PC, pa);
    exp_q.push_back(ITE_H_PRIV);
    exp_q.push_back(4'h9);
    seq(ITE_H_PC, pb);
    // without stall a second event while busy is lost; the first still goes out
    reg_write(ITE_ADDR_CTRL, ctrl(8'h01, ITE_FULL_WRAP, 1'b0, 1'b0));
    go(ITE_K_JAL, 1'b0, 1'b0, 1'b0, 1'b0);
    go(ITE_K_JAL, 1'b0, 1'b0, 1'b0, 1'b0);
    seq(ITE_H_PC, pa);
    exp_q.push_back(ITE_H_TROFF);
    seq(ITE_H_PC, pb);
    reg_write(ITE_ADDR_CTRL, ctrl(8'h01, ITE_FULL_WRAP, 1'b1, 1'b0));
    wait_idle();
    go(ITE_K_JAL, 1'b0, 1'b0, 1'b0, 1'b1);
    seq(ITE_H_PC, pa);
    seq(ITE_H_PC, pb);
    nw = exp_q.size() / 8;
    for (int i = 0; i < nw; i++)
    begin
      for (int j = 0; j < 8; j++)
        w[4*j +: 4] = exp_q[8*i + j];
      check("trace word", w, ite_ram_model_i.mem[32'h1000 + 4*i]);
    end
    rd_chk(ITE_ADDR_WPTR, 32'h1000 + 32'(4*nw), "wptr after");
    // small region: wrap, then stop, then exception
    reg_write(ITE_ADDR_START, 32'h3000);
    reg_write(ITE_ADDR_END, 32'h3040);
    reg_write(ITE_ADDR_CTRL, ctrl(8'h01, ITE_FULL_WRAP, 1'b1, 1'b1));
    repeat (12) go(ITE_K_JAL, 1'b0, 1'b0, 1'b0, 1'b1);
    rd_chk(ITE_ADDR_CTRL, ctrl(8'h01, 2'h0, 1'b1, 1'b0) | 32'h0100_0001, "wrapped");
    check("end untouched", 32'h0, 32'(ite_ram_model_i.mem.exists(32'h3040)));
    // 64-byte region: a header every 8 bytes
    for (int i = 0; i < ITE_SYNC_POINTS; i++)
      check("sync point", 32'(ITE_H_PC),
        32'(ite_ram_model_i.mem[32'h3000 + 8*i][3:0]));
    reg_write(ITE_ADDR_CTRL, ctrl(8'h01, ITE_FULL_STOP, 1'b1, 1'b1));
    rd_chk(ITE_ADDR_WPTR, 32'h3000, "wptr rewind");
    rd_chk(ITE_ADDR_CTRL, ctrl(8'h01, 2'h1, 1'b1, 1'b0) | 32'h1, "wrapped clear");
    nw = ite_ram_model_i.nwr;
    repeat (12) go(ITE_K_JAL, 1'b0, 1'b0, 1'b0, 1'b0);
    check("stop writes", 32'h10, 32'(ite_ram_model_i.nwr - nw));
    check("stop no wrap", 32'h0, 32'(ite_ram_model_i.mem.exists(32'h3040)));
    reg_write(ITE_ADDR_CTRL, ctrl(8'h01, ITE_FULL_EXC, 1'b1, 1'b1));
    go(ITE_K_JAL, 1'b0, 1'b0, 1'b0, 1'b1);
    repeat (12) go(ITE_K_JAL, 1'b0, 1'b0, 1'b0, 1'b0);
    check("full exception", 32'h1, 32'(n_exc));
    final_report();
  end
endmodule // tb_top
